/* hdl/adc_ctrl_pkg.sv */
// Constants shared by the converter control logic
package adc_ctrl_pkg;
	localparam int        DATA_W          = 16;
	localparam int        PAIRS           = 3;
	localparam int        CONV_TIME_NS    = 3000;
	localparam int        CLK_PERIOD_NS   = 4;
	localparam int        CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int        CNT_W           = 12;
	// Control register field positions and reset value
	localparam int        CTRL_W          = 8;
	localparam int        CTRL_SEL_LSB    = 0;
	localparam int        CTRL_RNG_LSB    = 3;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	// Data lines with special meaning
	localparam int        REFERENCE_BUFFER_ENABLE_LINE     = 14;
	localparam int        BYTE_ORDER_LINE = 7;
	// Variant resolution for leading zeros
	localparam int        RES_16          = 16;
	localparam int        RES_14          = 14;
	localparam int        RES_12          = 12;
	typedef enum logic [2:0] {
		ST_ARMED = 3'b001,
		ST_IDLE  = 3'b010,
		ST_BUSY  = 3'b100
	} conv_state_t;
endpackage : adc_ctrl_pkg

/* hdl/result_store.sv */
// Small register memory holding the six conversion results
`timescale 1ns/1ps
module result_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 6
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     wr_en_in,
	input  wire logic [2:0]               wr_addr_in,
	input  wire logic [WIDTH-1:0]         wr_data_in,
	input  wire logic [2:0]               rd_addr_in,
	output logic      [WIDTH-1:0]         rd_data_out
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= '0;
		end else if (int'(rd_addr_in) < DEPTH) begin
			rd_data_out <= mem[rd_addr_in];
		end else begin
			rd_data_out <= '0;
		end
	end
endmodule : result_store

/* hdl/adc_control_pin_logic.sv */
// Control, range, standby, pair selection and parallel output logic of a six channel converter
`timescale 1ns/1ps
// Behaviour
// - Reset input high aborts conversion, resets device
// - Reset clears control register to zero
// - Hardware mode configuration from select pins
// - Full start pulse needed after reset
// - Hardware mode samples range at busy fall
// - Software mode takes range from register bits
// - Standby low puts all converters in standby
// - Mode select picks pins or register pairs
// - Serial software mode starts from pair A
// - Byte mode uses upper lines, line 7 orders
// - Serial mode: line 14 enables reference buffers
// - Narrow variants drive leading zeros on lines 15 and 14, down to line 12 at 12 bits
// - Byte order high gives MSB first
module adc_control_pin_logic
	import adc_ctrl_pkg::*;
#(
	parameter int RESOLUTION  = adc_ctrl_pkg::RES_16,
	parameter int CONV_CYC    = adc_ctrl_pkg::CONV_CYCLES
) (
	input  wire logic                          clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic                          reset_in,
	input  wire logic [adc_ctrl_pkg::PAIRS-1:0] conversion_start_in,
	input  wire logic                          range_in,
	input  wire logic                          standby_n_in,
	input  wire logic                          hw_sw_select_in,
	input  wire logic                          serial_parallel_select_in,
	input  wire logic                          word_byte_in,
	input  wire logic                          read_n_in,
	input  wire logic                          write_n_in,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0] data_line_in,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0] sample_in,
	input  wire logic [3:0]                    reg_addr_in,
	input  wire logic [7:0]                    reg_wdata_in,
	input  wire logic                          reg_write_in,
	input  wire logic                          reg_read_in,
	output logic      [7:0]                    reg_rdata_out,
	output logic      [adc_ctrl_pkg::DATA_W-1:0] data_line_out,
	output logic                               data_line_oe_out,
	output logic                               busy_out,
	output logic      [adc_ctrl_pkg::PAIRS-1:0] pair_range_out,
	output logic                               standby_out,
	output logic                               reference_buffer_enable_out,
	output logic      [adc_ctrl_pkg::PAIRS-1:0] pair_converting_out
);
	import adc_ctrl_pkg::*;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;

	// ==========================================================
	// Input synchronisers
	localparam int SYNC_W = 10;
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [DATA_W-1:0] line_a;
	logic [DATA_W-1:0] line_b;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Idle pin levels, so no false strobe or start edge follows reset
			sync_a <= 10'h317;
			sync_b <= 10'h317;
		end else begin
			sync_a <= {write_n_in, read_n_in, word_byte_in, serial_parallel_select_in, hw_sw_select_in,
				standby_n_in, range_in, conversion_start_in};
			sync_b <= sync_a;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_a <= '0;
			line_b <= '0;
		end else begin
			line_a <= data_line_in;
			line_b <= line_a;
		end
	end

	logic              reset_a;
	logic              reset_s;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reset_a <= 1'b1;
			reset_s <= 1'b1;
		end else begin
			reset_a <= reset_in;
			reset_s <= reset_a;
		end
	end

	logic [PAIRS-1:0] cs_s;
	logic             range_s;
	logic             standby_n_s;
	logic             hw_sw_s;
	logic             serial_s;
	logic             byte_mode_s;
	logic             rd_n_s;
	logic             wr_n_s;
	assign cs_s        = sync_b[2:0];
	assign range_s     = sync_b[3];
	assign standby_n_s = sync_b[4];
	assign hw_sw_s     = sync_b[5];
	assign serial_s    = sync_b[6];
	assign byte_mode_s = sync_b[7];
	assign rd_n_s      = sync_b[8];
	assign wr_n_s      = sync_b[9];

	// ==========================================================
	// Control register
	logic [CTRL_W-1:0] ctrl;
	logic              wr_n_d;
	logic              pin_write;
	assign pin_write = wr_n_d && !wr_n_s && !serial_s;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_n_d <= 1'b1;
		end else begin
			wr_n_d <= wr_n_s;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= CTRL_RESET;
		end else if (reset_s) begin
			ctrl <= CTRL_RESET;
		end else if (reg_write_in && reg_addr_in == OFS_CTRL) begin
			ctrl <= reg_wdata_in;
		end else if (pin_write) begin
			ctrl <= line_b[DATA_W-1 -: CTRL_W];
		end
	end

	logic [PAIRS-1:0] sw_sel;
	logic [PAIRS-1:0] sw_rng;
	assign sw_sel = ctrl[CTRL_SEL_LSB +: PAIRS];
	assign sw_rng = ctrl[CTRL_RNG_LSB +: PAIRS];

	// ==========================================================
	// Start detection
	logic [PAIRS-1:0] cs_d;
	logic [PAIRS-1:0] cs_fall_seen;
	logic [PAIRS-1:0] cs_rise;
	logic [PAIRS-1:0] start_req;
	logic [PAIRS-1:0] eff_cs;

	always_comb begin
		if (hw_sw_s && serial_s) begin
			eff_cs = {PAIRS{cs_s[0]}};
		end else begin
			eff_cs = cs_s;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_d <= '1;
		end else begin
			cs_d <= eff_cs;
		end
	end

	assign cs_rise = eff_cs & ~cs_d;

	// A start counts only after its own falling edge has been seen
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_fall_seen <= '0;
		end else if (reset_s) begin
			cs_fall_seen <= '0;
		end else begin
			cs_fall_seen <= (cs_fall_seen | (~eff_cs & cs_d)) & ~cs_rise;
		end
	end

	always_comb begin
		start_req = cs_rise & cs_fall_seen;
		if (hw_sw_s) begin
			start_req = (|start_req) ? sw_sel : '0;
		end
	end

	// ==========================================================
	// Conversion sequencer
	conv_state_t      state;
	conv_state_t      next_state;
	logic [CNT_W-1:0] conv_cnt;
	logic [PAIRS-1:0] active;
	logic             conv_done;
	assign conv_done = (state == ST_BUSY) && (conv_cnt == CNT_W'(CONV_CYC - 1));

	always_comb begin
		next_state = state;
		case (state)
			ST_ARMED: begin
				if (|start_req && standby_n_s) begin
					next_state = ST_BUSY;
				end
			end
			ST_IDLE: begin
				if (|start_req && standby_n_s) begin
					next_state = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (conv_done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_ARMED;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_ARMED;
		end else if (reset_s) begin
			state <= ST_ARMED;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			conv_cnt <= '0;
		end else if (state != ST_BUSY || reset_s) begin
			conv_cnt <= '0;
		end else begin
			conv_cnt <= conv_cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active <= '0;
		end else if (reset_s) begin
			active <= '0;
		end else if (state != ST_BUSY && next_state == ST_BUSY) begin
			active <= start_req;
		end else if (conv_done) begin
			active <= '0;
		end
	end

	// ==========================================================
	// Range selection
	logic [PAIRS-1:0] hw_range;

	// Pin range caught while reset is held and at end of conversion
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hw_range <= '0;
		end else if (reset_s) begin
			hw_range <= {PAIRS{range_s}};
		end else if (conv_done) begin
			hw_range <= {PAIRS{range_s}};
		end
	end

	// Applied range is frozen while busy
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pair_range_out <= '0;
		end else if (state != ST_BUSY) begin
			pair_range_out <= hw_sw_s ? sw_rng : hw_range;
		end
	end

	// ==========================================================
	// Result capture
	logic [2:0]        wr_idx;
	logic [2:0]        rd_idx;
	logic [DATA_W-1:0] rd_word;
	logic              cap_en;
	assign cap_en = conv_done;

	result_store #(
		.WIDTH(DATA_W),
		.DEPTH(2 * PAIRS)
	) u_store (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (cap_en),
		.wr_addr_in (wr_idx),
		.wr_data_in (sample_in),
		.rd_addr_in (rd_idx),
		.rd_data_out(rd_word)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_idx <= '0;
		end else if (reset_s) begin
			wr_idx <= '0;
		end else if (cap_en) begin
			wr_idx <= (wr_idx == 3'(2 * PAIRS - 1)) ? 3'h0 : wr_idx + 3'h1;
		end
	end

	// ==========================================================
	// Parallel read path
	logic rd_n_d;
	logic rd_end;
	logic byte_second;
	assign rd_end = !rd_n_d && rd_n_s;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_n_d <= 1'b1;
		end else begin
			rd_n_d <= rd_n_s;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byte_second <= 1'b0;
			rd_idx      <= '0;
		end else if (reset_s) begin
			byte_second <= 1'b0;
			rd_idx      <= '0;
		end else if (rd_end) begin
			if (byte_mode_s && !byte_second) begin
				byte_second <= 1'b1;
			end else begin
				byte_second <= 1'b0;
				rd_idx      <= (rd_idx == 3'(2 * PAIRS - 1)) ? 3'h0 : rd_idx + 3'h1;
			end
		end
	end

	function automatic logic [DATA_W-1:0] mask_word(input logic [DATA_W-1:0] w);
		logic [DATA_W-1:0] m;
		m = w;
		if (RESOLUTION < RES_16) begin
			m[DATA_W-1] = 1'b0;
		end
		if (RESOLUTION <= RES_12) begin
			m[REFERENCE_BUFFER_ENABLE_LINE] = 1'b0;
			m[13]          = 1'b0;
			m[12]          = 1'b0;
		end else if (RESOLUTION <= RES_14) begin
			m[REFERENCE_BUFFER_ENABLE_LINE] = 1'b0;
		end
		return m;
	endfunction : mask_word

	logic [DATA_W-1:0] word_m;
	logic              msb_first;
	assign word_m    = mask_word(rd_word);
	assign msb_first = line_b[BYTE_ORDER_LINE];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_line_out <= '0;
		end else if (!byte_mode_s) begin
			data_line_out <= word_m;
		end else if (msb_first ^ byte_second) begin
			data_line_out <= {word_m[15:8], 8'h00};
		end else begin
			data_line_out <= {word_m[7:0], 8'h00};
		end
	end

	assign data_line_oe_out = !serial_s && !rd_n_s && !reset_s;

	// ==========================================================
	// Standby, reference buffers and status
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			standby_out <= 1'b0;
		end else begin
			standby_out <= !standby_n_s;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reference_buffer_enable_out <= 1'b0;
		end else if (serial_s) begin
			reference_buffer_enable_out <= line_b[REFERENCE_BUFFER_ENABLE_LINE];
		end else begin
			reference_buffer_enable_out <= 1'b1;
		end
	end

	assign busy_out            = (state == ST_BUSY);
	assign pair_converting_out = active;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_read_in && reg_addr_in == OFS_CTRL) begin
			reg_rdata_out <= ctrl;
		end else if (reg_read_in && reg_addr_in == OFS_STATUS) begin
			reg_rdata_out <= {3'h0, pair_range_out, busy_out, state == ST_ARMED};
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// ==========================================================
	// Checks
	reset_abort_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		reset_s |=> !busy_out && active == '0)
		else $error("conversion survives reset");
	reset_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		reset_s |=> ctrl == CTRL_RESET)
		else $error("control register not cleared");
	start_armed_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_ARMED && $rose(reset_s) == 1'b0 && cs_fall_seen == '0) |=> state != ST_BUSY)
		else $error("conversion without full start pulse");
	range_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(busy_out && $past(busy_out)) |-> $stable(pair_range_out))
		else $error("range changed mid conversion");
	sw_range_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!busy_out && hw_sw_s && $stable(sw_rng) && $stable(hw_sw_s)) |=> pair_range_out == $past(sw_rng))
		else $error("software range not applied");
	standby_map_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$stable(standby_n_s) |=> standby_out == !$past(standby_n_s))
		else $error("standby output wrong");
	conv_len_a : assert property (@(posedge clk_in) disable iff (!rst_n_in || reset_s)
		$rose(busy_out) |-> busy_out [*8])
		else $error("conversion ended early");
	byte_upper_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$past(byte_mode_s) && byte_mode_s |-> data_line_out[7:0] == 8'h00)
		else $error("byte mode drives low lines");
endmodule : adc_control_pin_logic

/* sim/host_model.sv */
// Behavioural host driving the converter's control pins and parallel bus
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] bus_in,
	output logic             reset_out,
	output logic [2:0]       start_out,
	output logic             read_n_out,
	output logic             write_n_out,
	output logic [15:0]      drive_out
);
	initial begin
		reset_out   = 1'b0;
		start_out   = 3'h7;
		read_n_out  = 1'b1;
		write_n_out = 1'b1;
		drive_out   = 16'h0000;
	end

	// =====================================
	// Reset pulse of 25 cycles, start level as given
	task automatic pulse_reset(input logic lvl);
		@(posedge clk_in);
		start_out <= {3{lvl}};
		reset_out <= 1'b1;
		repeat (25) @(posedge clk_in);
		reset_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : pulse_reset

	task automatic set_start(input logic lvl);
		@(posedge clk_in);
		start_out <= {3{lvl}};
		repeat (4) @(posedge clk_in);
	endtask : set_start

	task automatic set_line(input int idx, input logic val);
		@(posedge clk_in);
		drive_out[idx] <= val;
		repeat (4) @(posedge clk_in);
	endtask : set_line

	// Full start pulse: fall then rise on the chosen pins
	task automatic start(input logic [2:0] pins);
		@(posedge clk_in);
		start_out <= start_out & ~pins;
		repeat (4) @(posedge clk_in);
		start_out <= start_out | pins;
	endtask : start

	// One read strobe; byte results need two of these
	task automatic read(output logic [15:0] d);
		@(posedge clk_in);
		read_n_out <= 1'b0;
		repeat (5) @(posedge clk_in);
		d = bus_in;
		read_n_out <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask : read
endmodule : host_model

/* sim/tb.sv */
// Self-checking bench for the converter control logic
`timescale 1ns/1ps
module tb;
	import adc_ctrl_pkg::*;
	localparam int CYC = 20;
	logic clk_in, rst_n_in, range_in, standby_n_in, hw_sw_select_in;
	logic serial_parallel_select_in, word_byte_in, reg_write_in, reg_read_in;
	logic [15:0] sample_in, data_line_in, data_line_out, host_d, d, narrow_line;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	logic [2:0] start, pair_range_out, pair_converting_out;
	logic reset_in, read_n, write_n, data_line_oe_out, busy_out, standby_out, reference_buffer_enable_out;
	int bad_count = 0;
	int checks = 0;

	// Device drives the bus while enabled; in byte mode the host keeps the low lines
	assign data_line_in = {data_line_oe_out ? data_line_out[15:8] : host_d[15:8],
		(data_line_oe_out && !word_byte_in) ? data_line_out[7:0] : host_d[7:0]};

	adc_control_pin_logic #(.RESOLUTION(RES_16), .CONV_CYC(CYC)) u_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .reset_in(reset_in), .conversion_start_in(start),
		.range_in(range_in), .standby_n_in(standby_n_in), .hw_sw_select_in(hw_sw_select_in),
		.serial_parallel_select_in(serial_parallel_select_in), .word_byte_in(word_byte_in),
		.read_n_in(read_n), .write_n_in(write_n), .data_line_in(data_line_in), .sample_in(sample_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .data_line_out(data_line_out),
		.data_line_oe_out(data_line_oe_out), .busy_out(busy_out), .pair_range_out(pair_range_out),
		.standby_out(standby_out), .reference_buffer_enable_out(reference_buffer_enable_out),
		.pair_converting_out(pair_converting_out));

	// Narrow variant on the same pins, watched only for its leading zeros
	adc_control_pin_logic #(.RESOLUTION(RES_14), .CONV_CYC(CYC)) u_narrow (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .reset_in(reset_in), .conversion_start_in(start),
		.range_in(range_in), .standby_n_in(standby_n_in), .hw_sw_select_in(hw_sw_select_in),
		.serial_parallel_select_in(serial_parallel_select_in), .word_byte_in(word_byte_in),
		.read_n_in(read_n), .write_n_in(write_n), .data_line_in(data_line_in), .sample_in(sample_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(), .data_line_out(narrow_line),
		.data_line_oe_out(), .busy_out(), .pair_range_out(), .standby_out(),
		.reference_buffer_enable_out(), .pair_converting_out());

	host_model u_host (.clk_in(clk_in), .bus_in(data_line_in), .reset_out(reset_in), .start_out(start),
		.read_n_out(read_n), .write_n_out(write_n), .drive_out(host_d));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// =====================================
	// Register port
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= v;
		reg_write_in <= 1'b1;
		@(posedge clk_in);
		reg_write_in <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clk_in);
		reg_read_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask : reg_rd

	// One conversion; range_in changes mid-way and the applied range must hold
	task automatic conv(input logic [2:0] pins, input logic [2:0] pairs, input logic rng, input logic mid,
			input logic [2:0] prev);
		int n;
		u_host.start(pins);
		n = 0;
		while (busy_out !== 1'b1 && n < 10) begin
			@(posedge clk_in);
			#1 n++;
		end
		check("busy rise", {15'h0, busy_out}, 16'h0001);
		check("pairs", {13'h0, pair_converting_out}, {13'h0, pairs});
		n = 0;
		while (busy_out === 1'b1 && n < 100) begin
			if (n == 3)
				range_in <= rng;
			if (n == 6 && mid)
				check("range held", {13'h0, pair_range_out}, {13'h0, prev});
			@(posedge clk_in);
			#1 n++;
		end
		check("busy length", n[15:0], CYC[15:0]);
		repeat (3) @(posedge clk_in);
	endtask : conv

	task automatic bytes(input logic order, input logic [7:0] b1, input logic [7:0] b2);
		logic [15:0] r;
		u_host.set_line(BYTE_ORDER_LINE, order);
		u_host.read(r);
		check("first byte", {8'h00, r[15:8]}, {8'h00, b1});
		u_host.read(r);
		check("second byte", {8'h00, r[15:8]}, {8'h00, b2});
	endtask : bytes

	initial begin
		logic [7:0] v;
		rst_n_in = 1'b0;
		range_in = 1'b1;
		standby_n_in = 1'b1;
		hw_sw_select_in = 1'b0;
		serial_parallel_select_in = 1'b0;
		word_byte_in = 1'b0;
		sample_in = 16'ha5c3;
		reg_addr_in = 4'h0;
		reg_wdata_in = 8'h00;
		reg_write_in = 1'b0;
		reg_read_in = 1'b0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// =====================================
		// Start low through reset: a bare rise must not convert
		u_host.pulse_reset(1'b0);
		u_host.set_start(1'b1);
		repeat (6) @(posedge clk_in);
		check("busy no fall", {15'h0, busy_out}, 16'h0000);
		reg_rd(4'h0, v);
		check("ctrl reset", {8'h00, v}, 16'h0000);
		reg_rd(4'h9, v);
		check("unmapped", {8'h00, v}, 16'h0000);
		// Hardware pair selection and range at busy fall
		conv(3'b011, 3'b011, 1'b1, 1'b1, 3'b111);
		check("range one", {13'h0, pair_range_out}, 16'h0007);
		u_host.read(d);
		check("word read", d, 16'ha5c3);
		check("narrow word", narrow_line, 16'h25c3);
		conv(3'b111, 3'b111, 1'b0, 1'b1, 3'b111);
		check("range zero", {13'h0, pair_range_out}, 16'h0000);
		word_byte_in <= 1'b1;
		bytes(1'b1, 8'ha5, 8'hc3);
		conv(3'b111, 3'b111, 1'b0, 1'b1, 3'b000);
		bytes(1'b0, 8'hc3, 8'ha5);
		word_byte_in <= 1'b0;
		// Register selection in serial mode, started by pair A only
		hw_sw_select_in <= 1'b1;
		serial_parallel_select_in <= 1'b1;
		reg_wr(4'h0, 8'h15);
		reg_rd(4'h0, v);
		check("ctrl write", {8'h00, v}, 16'h0015);
		conv(3'b001, 3'b101, 1'b1, 1'b0, 3'b000);
		check("soft range", {13'h0, pair_range_out}, 16'h0002);
		u_host.set_line(REFERENCE_BUFFER_ENABLE_LINE, 1'b1);
		check("reference_buffer_enable on", {15'h0, reference_buffer_enable_out}, 16'h0001);
		u_host.set_line(REFERENCE_BUFFER_ENABLE_LINE, 1'b0);
		check("reference_buffer_enable off", {15'h0, reference_buffer_enable_out}, 16'h0000);
		// Standby refuses starts
		standby_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		check("standby on", {15'h0, standby_out}, 16'h0001);
		u_host.start(3'b001);
		repeat (8) @(posedge clk_in);
		check("standby busy", {15'h0, busy_out}, 16'h0000);
		standby_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		check("standby off", {15'h0, standby_out}, 16'h0000);
		// Reset pin aborts a running conversion and clears control
		u_host.start(3'b001);
		repeat (7) @(posedge clk_in);
		check("busy before", {15'h0, busy_out}, 16'h0001);
		// Looked at before the conversion could have ended by itself
		fork
			u_host.pulse_reset(1'b1);
			begin
				repeat (12) @(posedge clk_in);
				check("abort", {15'h0, busy_out}, 16'h0000);
			end
		join
		reg_rd(4'h0, v);
		check("ctrl cleared", {8'h00, v}, 16'h0000);
		end_sim();
	end

	initial begin
		#100000;
		bad_count++;
		end_sim();
	end
endmodule : tb
